//--- shared/rbs_pkg.sv
// Shared constants and types for the reset and boot strap sampler
package rbs_pkg;

   // Core clock period and strap sampling delay after reset release
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned STRAP_DELAY_NS  = 1500;
   // Least time, so round up to whole cycles
   localparam int unsigned STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DELAY_CNT_W     = $clog2(STRAP_DELAY_CYC + 1);

   // Strap encodings
   localparam logic PORT_SEL_SPI   = 1'h0;
   localparam logic PORT_SEL_I2C   = 1'h1;
   localparam logic SPI_MODE_0_3   = 1'h0;
   localparam logic SPI_MODE_1_2   = 1'h1;
   localparam logic CHECK_CRC8     = 1'h0;
   localparam logic CHECK_CHECKSUM = 1'h1;

   // Park reset value and illumination select width
   localparam logic PARK_RESET   = 1'h1;
   localparam int unsigned ILLUM_W = 4;

   // Sequencer states
   typedef enum logic [1:0] {
      RBS_HELD,
      RBS_SETTLE,
      RBS_RUN
   } rbs_state_e;

   // The three boot straps, one bit each
   typedef struct packed {
      logic host_port_sel;
      logic spi_mode_sel;
      logic check_sel;
   } rbs_strap_s;

   localparam rbs_strap_s STRAP_RESET = '{host_port_sel: PORT_SEL_SPI, spi_mode_sel: SPI_MODE_0_3,
                                          check_sel: CHECK_CRC8};

   // Output pins that are driven low while reset is held
   typedef struct packed {
      logic [ILLUM_W-1:0] illumination_select;
      logic               mirror_array_enable_reset;
      logic               monitor_adc_clock;
      logic               monitor_adc_serial_out;
   } rbs_low_pins_s;

endpackage

//--- core/rbs_strap_latch.sv
// Holding latch for the sampled boot straps
`timescale 1ns/100ps
module rbs_strap_latch (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               clear,
   input  wire logic               capture,
   input  wire rbs_pkg::rbs_strap_s strap_in,
   output rbs_pkg::rbs_strap_s     strap_q,
   output logic                    valid_q
);

   // Capture once per release; pin activity afterwards is ignored
   always_ff @(posedge clk_sys) begin
      if (reset || clear) begin
         strap_q <= rbs_pkg::STRAP_RESET;
         valid_q <= 1'b0;
      end else if (capture && !valid_q) begin
         strap_q <= strap_in;
         valid_q <= 1'b1;
      end
   end

endmodule

//--- core/rbs_sampler.sv
// Power-on reset handling, pin states under reset and boot strap sampling
`timescale 1ns/100ps
module rbs_sampler #(
   parameter int unsigned OTHER_W = 8
) (
   input  wire logic                   clk_sys,
   input  wire logic                   reset,
   // Board-level pins
   input  wire logic                   power_on_reset_low,
   input  wire logic                   park_request_low,
   output rbs_pkg::rbs_low_pins_s      low_pins_out,
   input  wire rbs_pkg::rbs_strap_s    strap_pin_in,
   output rbs_pkg::rbs_strap_s         strap_pin_out,
   output rbs_pkg::rbs_strap_s         strap_pin_oe,
   output logic [OTHER_W-1:0]          other_pin_out,
   output logic [OTHER_W-1:0]          other_pin_oe,
   // Core side
   input  wire rbs_pkg::rbs_low_pins_s low_pins_user,
   input  wire rbs_pkg::rbs_strap_s    strap_debug_out,
   input  wire rbs_pkg::rbs_strap_s    strap_debug_en,
   input  wire logic [OTHER_W-1:0]     other_out_user,
   input  wire logic [OTHER_W-1:0]     other_oe_user,
   input  wire logic                   flash_monitor_check,
   output logic                        core_reset_hold,
   output logic                        straps_valid,
   output rbs_pkg::rbs_strap_s         straps,
   output logic                        mirror_park,
   output logic                        cmd_port_i2c,
   output logic                        monitor_port_i2c,
   output logic                        host_spi_mode_alt,
   output logic                        cmd_check_checksum,
   output logic                        monitor_check_checksum
);

   rbs_pkg::rbs_state_e                state_q;
   rbs_pkg::rbs_state_e                state_d;
   logic [rbs_pkg::DELAY_CNT_W-1:0]    cnt_q;
   logic [rbs_pkg::DELAY_CNT_W-1:0]    cnt_d;
   logic                               held;
   logic                               running;
   logic                               capture;
   logic                               delay_done;

   // Decode of the sequencer state
   assign held            = (state_q == rbs_pkg::RBS_HELD);
   assign running         = (state_q == rbs_pkg::RBS_RUN);
   assign delay_done      = (cnt_q == (rbs_pkg::DELAY_CNT_W)'(rbs_pkg::STRAP_DELAY_CYC - 1));
   // Pin can drop mid-delay, so capture also needs it still high
   assign capture         = (state_q == rbs_pkg::RBS_SETTLE) && delay_done && power_on_reset_low;
   assign core_reset_hold = held;

   // Next state: a low reset pin always wins and returns to held
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      if (!power_on_reset_low) begin
         state_d = rbs_pkg::RBS_HELD;
         cnt_d   = '0;
      end else begin
         unique case (state_q)
            rbs_pkg::RBS_HELD: begin
               state_d = rbs_pkg::RBS_SETTLE;
               cnt_d   = '0;
            end
            rbs_pkg::RBS_SETTLE: begin
               if (delay_done) begin
                  state_d = rbs_pkg::RBS_RUN;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            rbs_pkg::RBS_RUN: begin
               state_d = rbs_pkg::RBS_RUN;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= rbs_pkg::RBS_HELD;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Strap holder, cleared whenever reset is held again
   rbs_strap_latch u_latch (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .clear    (held),
      .capture  (capture),
      .strap_in (strap_pin_in),
      .strap_q  (straps),
      .valid_q  (straps_valid)
   );

   // Pin drive: forced low or released while held, user values after, except strap enables stay off until running
   always_ff @(posedge clk_sys) begin
      if (reset || held) begin
         low_pins_out  <= '0;
         other_pin_out <= '0;
         other_pin_oe  <= '0;
         strap_pin_out <= '0;
         strap_pin_oe  <= '0;
      end else begin
         low_pins_out  <= low_pins_user;
         other_pin_out <= other_out_user;
         other_pin_oe  <= other_oe_user;
         strap_pin_out <= strap_debug_out;
         // Debug drive only after sampling, else we would read our own value
         strap_pin_oe  <= running ? strap_debug_en : '0;
      end
   end

   // Park follows the request; also parked while in reset for safety
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mirror_park <= rbs_pkg::PARK_RESET;
      end else begin
         mirror_park <= held || !park_request_low;
      end
   end

   // Port roles, SPI mode and command packet check from the held straps; monitor check from flash_monitor_check
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_port_i2c           <= rbs_pkg::PORT_SEL_SPI;
         monitor_port_i2c       <= rbs_pkg::PORT_SEL_I2C;
         host_spi_mode_alt      <= rbs_pkg::SPI_MODE_0_3;
         cmd_check_checksum     <= rbs_pkg::CHECK_CRC8;
         monitor_check_checksum <= rbs_pkg::CHECK_CRC8;
      end else begin
         cmd_port_i2c           <= straps.host_port_sel == rbs_pkg::PORT_SEL_I2C;
         monitor_port_i2c       <= straps.host_port_sel != rbs_pkg::PORT_SEL_I2C;
         // One mode output feeds the SPI port whatever its role
         host_spi_mode_alt      <= straps.spi_mode_sel;
         cmd_check_checksum     <= straps.check_sel == rbs_pkg::CHECK_CHECKSUM;
         monitor_check_checksum <= flash_monitor_check;
      end
   end

   // Checks on the behaviour above
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Sampling lag follows the package delay so the check cannot drift from it
   localparam int SAMPLE_LAG = int'(rbs_pkg::STRAP_DELAY_CYC);
   localparam int SAMPLE_PRE = SAMPLE_LAG + 1;

   sequence s_release;
      core_reset_hold && power_on_reset_low;
   endsequence

   sequence s_high_run;
      power_on_reset_low [*8];
   endsequence

   property p_hold_on_low;
      !power_on_reset_low |=> core_reset_hold;
   endproperty
   a_hold_on_low: assert property (p_hold_on_low) else $error("reset pin low but core not held");

   property p_release_starts;
      s_release |=> !core_reset_hold;
   endproperty
   a_release_starts: assert property (p_release_starts) else $error("rise of reset pin did not start");

   property p_low_pins;
      core_reset_hold |=> low_pins_out == '0;
   endproperty
   a_low_pins: assert property (p_low_pins) else $error("forced-low pins not low in reset");

   property p_tristate;
      core_reset_hold |=> other_pin_oe == '0 && strap_pin_oe == '0;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pin enabled while reset held");

   property p_park;
      !park_request_low |=> mirror_park;
   endproperty
   a_park: assert property (p_park) else $error("park request ignored");

   property p_unpark;
      park_request_low && !core_reset_hold |=> !mirror_park;
   endproperty
   a_unpark: assert property (p_unpark) else $error("un-park request ignored");

   property p_sample_time;
      $rose(straps_valid) |-> $past(core_reset_hold, SAMPLE_PRE) && !$past(core_reset_hold, SAMPLE_LAG);
   endproperty
   a_sample_time: assert property (p_sample_time) else $error("straps sampled at wrong time");

   property p_no_early;
      s_release ##1 s_high_run |-> !straps_valid;
   endproperty
   a_no_early: assert property (p_no_early) else $error("straps valid too early");

   property p_strap_stable;
      // A short low pulse re-enters held, which clears the latch on purpose
      straps_valid && power_on_reset_low && !core_reset_hold |=> $stable(straps) && straps_valid;
   endproperty
   a_strap_stable: assert property (p_strap_stable) else $error("latched straps changed");

   property p_port_roles;
      straps_valid |=> cmd_port_i2c == $past(straps.host_port_sel) && monitor_port_i2c != cmd_port_i2c;
   endproperty
   a_port_roles: assert property (p_port_roles) else $error("port roles wrong");

   property p_spi_mode;
      straps_valid |=> host_spi_mode_alt == $past(straps.spi_mode_sel);
   endproperty
   a_spi_mode: assert property (p_spi_mode) else $error("SPI mode wrong");

   property p_checks;
      straps_valid |=> cmd_check_checksum == $past(straps.check_sel)
                       && monitor_check_checksum == $past(flash_monitor_check);
   endproperty
   a_checks: assert property (p_checks) else $error("packet check select wrong");

endmodule

//--- verif/rbs_board_model.sv
// Board side: strap pulls, power manager reset and park lines
`timescale 1ns/100ps
module rbs_board_model (
   input  wire logic                clk_sys,
   input  wire logic                por_req,
   input  wire logic                power_good,
   input  wire rbs_pkg::rbs_strap_s strap_pull,
   input  wire rbs_pkg::rbs_strap_s strap_pin_out,
   input  wire rbs_pkg::rbs_strap_s strap_pin_oe,
   output logic                     power_on_reset_low,
   output logic                     park_request_low,
   output rbs_pkg::rbs_strap_s      strap_pin_in
);
   // Reset released only on a running clock, so clocks are stable first
   always_ff @(posedge clk_sys) begin
      power_on_reset_low <= por_req;
   end
   // Manager pulls park low on looming power loss
   assign park_request_low = power_good;
   // Undriven strap pins settle to the board pull level
   assign strap_pin_in = (strap_pin_oe & strap_pin_out) | (~strap_pin_oe & strap_pull);
endmodule

//--- verif/rbs_sampler_tb_top.sv
// Self-checking bench for the reset and boot strap sampler
`timescale 1ns/100ps
module rbs_sampler_tb_top;
   localparam int D = rbs_pkg::STRAP_DELAY_CYC;
   logic clk_sys, reset, por, pgood, flash, rst_hold, sv, cp, mp, sm, cc, mc, pl, mpark;
   logic [2:0] pull, dbg_o, dbg_e;
   logic [6:0] lusr;
   logic [7:0] ousr;
   rbs_pkg::rbs_strap_s spi, spo, soe, st;
   rbs_pkg::rbs_low_pins_s lpo;
   logic [7:0] opo, poe;
   logic mc_chk;
   int n_fail, checks_done, cyc;
   rbs_board_model BRD (.clk_sys(clk_sys), .por_req(por), .power_good(pgood), .strap_pull(pull),
      .strap_pin_out(spo), .strap_pin_oe(soe), .power_on_reset_low(pl), .park_request_low(mpark),
      .strap_pin_in(spi));
   rbs_sampler DUT (.clk_sys(clk_sys), .reset(reset), .power_on_reset_low(pl), .park_request_low(mpark),
      .low_pins_out(lpo), .strap_pin_in(spi), .strap_pin_out(spo), .strap_pin_oe(soe),
      .other_pin_out(opo), .other_pin_oe(poe), .low_pins_user(lusr), .strap_debug_out(dbg_o),
      .strap_debug_en(dbg_e), .other_out_user(ousr), .other_oe_user(ousr),
      .flash_monitor_check(flash), .core_reset_hold(rst_hold), .straps_valid(sv), .straps(st),
      .mirror_park(mp), .cmd_port_i2c(cp), .monitor_port_i2c(mc), .host_spi_mode_alt(sm),
      .cmd_check_checksum(cc), .monitor_check_checksum(mc_chk));
   // Compare one value and count the outcome
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Pins under held reset ignore the core's requests
   task t_held;
      @(posedge clk_sys) por <= 1'h0;
      dbg_e <= 3'h7;
      repeat (4) @(posedge clk_sys);
      #1 chk(lpo, 7'h00);
      chk({soe, poe}, 11'h000);
      chk({spo, opo}, 11'h000);
      chk({rst_hold, sv, mp}, 3'h5);
      @(posedge clk_sys) dbg_e <= 3'h0;
   endtask
   // Release and sample one strap setting, then disturb the pins
   task t_boot(input logic [2:0] s, input logic fl);
      @(posedge clk_sys) por <= 1'h0;
      pull <= s;
      flash <= fl;
      repeat (4) @(posedge clk_sys);
      #1 chk(sv, 1'h0);
      @(posedge clk_sys) por <= 1'h1;
      repeat (D + 1) @(posedge clk_sys);
      #1 chk(sv, 1'h0);
      chk(rst_hold, 1'h0);
      chk(lpo, lusr);
      @(posedge clk_sys);
      #1 chk(sv, 1'h1);
      chk(st, s);
      @(posedge clk_sys);
      #1 chk(cp, s[2]);
      chk(mc, !s[2]);
      chk(sm, s[1]);
      chk(sm, s[1]);
      chk(cc, s[0]);
      chk(mc_chk, fl);
      @(posedge clk_sys) pull <= ~s;
      dbg_e <= 3'h7;
      dbg_o <= ~s;
      repeat (3) @(posedge clk_sys);
      #1 chk(soe, 3'h7);
      chk(spo, dbg_o);
      chk(opo, ousr);
      chk({st, cp}, {s, s[2]});
      @(posedge clk_sys) dbg_e <= 3'h0;
   endtask
   // A low pulse inside the delay restarts the count
   task t_abort;
      @(posedge clk_sys) por <= 1'h0;
      repeat (3) @(posedge clk_sys) por <= 1'h1;
      repeat (10) @(posedge clk_sys) por <= 1'h0;
      @(posedge clk_sys) por <= 1'h1;
      repeat (D) @(posedge clk_sys);
      #1 chk(sv, 1'h0);
      repeat (2) @(posedge clk_sys);
      #1 chk(sv, 1'h1);
   endtask
   // Park follows the manager line one cycle late
   task t_park;
      @(posedge clk_sys) pgood <= 1'h0;
      repeat (2) @(posedge clk_sys);
      #1 chk(mp, 1'h1);
      @(posedge clk_sys) pgood <= 1'h1;
      repeat (2) @(posedge clk_sys);
      #1 chk(mp, 1'h0);
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Hang guard, well past the expected run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      reset = 1'h1;
      por = 1'h0;
      pgood = 1'h1;
      flash = 1'h0;
      pull = 3'h0;
      dbg_o = 3'h0;
      dbg_e = 3'h0;
      lusr = 7'h55;
      ousr = 8'hA5;
      repeat (4) @(posedge clk_sys);
      reset <= 1'h0;
      t_held();
      for (int i = 0; i < 8; i++) begin
         t_boot(i[2:0], i[0] ^ i[2]);
      end
      t_park();
      #1 chk(poe, 8'hA5);
      t_abort();
      stop_test();
   end
endmodule
